/* common/teo_chan_if.sv */
`timescale 1ns/10ps
// control side to one output channel
interface teo_chan_if;
    logic push;
    logic [31:0] push_pat;
    logic [31:0] push_ts;
    logic start;
    logic clear;
    logic rel_mode;
    logic [31:0] timer;
    logic [9:0] free;
    logic fire;
    logic [31:0] fire_pat;
    logic running;
    modport chan (
        input push, push_pat, push_ts, start, clear, rel_mode,
        output timer, free, fire, fire_pat, running
    );
    modport ctrl (
        output push, push_pat, push_ts, start, clear, rel_mode,
        input timer, free, fire, fire_pat, running
    );
endinterface

/* common/teo_pkg.sv */
// Operation
// - mode 1 absolute stamps, mode 3 relative
// - absolute stamp counts from channel start
// - relative stamp counts from previous output
// - start mask: bit0 channel 1, bit1 channel 2
// - start zeroes the channel time counter
// - counter steps once per 10 ns
// - 32-bit counter wraps silently, no overflow flag
// - each write pushes pattern plus stamp
// - channel 1 to lines 31:0, channel 2 41:32
// - queue holds 511; writes when full dropped
// - stamps count in 10 ns steps
// - counter matches head stamp: drive pattern
// - driven entry leaves queue, freeing slot
// - entries served strictly first in first out
// - late absolute stamp waits for counter wrap
// - late relative stamp fires at once
// - sync start input starts like start command
// - clear stops output and empties queue
// - clear also zeroes the time counter
// - enable mask picks scheduled versus static lines
// - free slot count readable, 0 to 511
package teo_pkg;

    // ***************************************************
    // timing
    // ***************************************************
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_PERIOD_NS = 10;
    localparam int TICK_DIV = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // ***************************************************
    // sizes
    // ***************************************************
    localparam int FIFO_DEPTH = 511;
    localparam int FREE_W = 10;
    localparam int NUM_CH = 2;
    localparam int HI_W = 10;

    // ***************************************************
    // register map
    // ***************************************************
    localparam logic [7:0] A_START = 8'h00;
    localparam logic [7:0] A_CLEAR = 8'h04;
    localparam logic [7:0] A_SYNC_MASK = 8'h08;
    localparam logic [7:0] A_STATIC_LO = 8'h0c;
    localparam logic [7:0] A_STATIC_HI = 8'h10;
    localparam logic [7:0] A_STATUS = 8'h14;
    localparam logic [4:0] O_MODE = 5'h00;
    localparam logic [4:0] O_ENABLE = 5'h04;
    localparam logic [4:0] O_PATTERN = 5'h08;
    localparam logic [4:0] O_STAMP = 5'h0c;
    localparam logic [4:0] O_FREE = 5'h10;
    localparam logic [4:0] O_TIMER = 5'h14;
    localparam int CH_SEL_LSB = 5;

    // ***************************************************
    // fields and reset values
    // ***************************************************
    localparam int MODE_LSB = 0;
    localparam logic [1:0] MODE_ABS = 2'h1;
    localparam logic [1:0] MODE_REL = 2'h3;
    localparam logic [1:0] MODE_RST = MODE_ABS;
    localparam logic [31:0] ENABLE_RST = 32'h0;
    localparam logic [31:0] STATIC_RST = 32'h0;
    localparam logic [1:0] SYNC_MASK_RST = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        TEO_IDLE = 2'b01,
        TEO_RUN = 2'b10
    } teo_run_t;

endpackage

/* hw/teo_channel.sv */
`timescale 1ns/10ps
module teo_channel import teo_pkg::*; #(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int DIV = TICK_DIV
) (
    input wire logic aclk,
    input wire logic aresetn,
    teo_chan_if.chan ch
);
    localparam int PW = $clog2(DEPTH);
    localparam int PSW = (DIV > 1) ? $clog2(DIV) : 1;

    if (DEPTH < 2 || DEPTH > 511 || DIV < 1) begin : g_chk
        $error("teo_channel: depth or divider out of range");
    end

    // ***************************************************
    // queue storage and state
    // ***************************************************
    logic [63:0] mem [2**PW];
    logic [PW-1:0] wr_q, rd_q;
    logic [FREE_W-1:0] cnt_q;
    logic [31:0] timer_q, since_q;
    logic [PSW-1:0] presc_q;
    teo_run_t st_q;

    wire running = (st_q == TEO_RUN);
    wire full = (cnt_q == FREE_W'(DEPTH));
    wire empty = (cnt_q == '0);
    wire [31:0] head_pat = mem[rd_q][63:32];
    wire [31:0] head_ts = mem[rd_q][31:0];
    wire tick_start = (presc_q == '0);
    wire tick_end = (presc_q == PSW'(DIV - 1));
    wire push_ok = ch.push && !full && !ch.clear;
    // absolute: exact equality, so a stale stamp waits for the wrap
    wire due_abs = (head_ts == timer_q);
    // relative: late heads go out at once
    wire due_rel = (since_q >= head_ts);
    wire due = ch.rel_mode ? due_rel : due_abs;
    wire fire = running && !empty && tick_start && due
        && !ch.start && !ch.clear;
    wire [FREE_W-1:0] cnt_d = cnt_q + FREE_W'(push_ok) - FREE_W'(fire);

    assign ch.timer = timer_q;
    assign ch.free = FREE_W'(DEPTH) - cnt_q;
    assign ch.fire = fire;
    assign ch.fire_pat = head_pat;
    assign ch.running = running;

    // storage has no reset; only pointers define contents
    always_ff @(posedge aclk) begin
        if (push_ok) begin
            mem[wr_q] <= {ch.push_pat, ch.push_ts};
        end
    end

    // pointers, count, run state
    always_ff @(posedge aclk) begin
        if (!aresetn || ch.clear) begin
            st_q <= TEO_IDLE;
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (ch.start) begin
                st_q <= TEO_RUN;
            end
            wr_q <= wr_q + PW'(push_ok);
            rd_q <= rd_q + PW'(fire);
            cnt_q <= cnt_d;
        end
    end

    // time base: one step per 10 ns, restarted at zero by start
    always_ff @(posedge aclk) begin
        if (!aresetn || ch.clear || ch.start) begin
            timer_q <= '0;
            since_q <= '0;
            presc_q <= '0;
        end else if (running) begin
            presc_q <= tick_end ? '0 : presc_q + 1'b1;
            if (tick_end) begin
                timer_q <= timer_q + 32'h1;
            end
            if (fire) begin
                since_q <= tick_end ? 32'h1 : 32'h0;
            end else if (tick_end && since_q != 32'hffff_ffff) begin
                since_q <= since_q + 32'h1;
            end
        end
    end

    // ***************************************************
    // checks
    // ***************************************************
    sequence s_start;
        ch.start && !ch.clear;
    endsequence

    a_queue_bound: assert property (@(posedge aclk) disable iff (!aresetn)
        cnt_q <= FREE_W'(DEPTH)) else $error("queue overfilled");
    a_full_drops: assert property (@(posedge aclk) disable iff (!aresetn)
        full && ch.push && !fire && !ch.clear |=> cnt_q == $past(cnt_q))
        else $error("write stored into full queue");
    a_start_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        s_start |=> timer_q == 32'h0 && running)
        else $error("start did not zero counter");
    a_timer_step: assert property (@(posedge aclk) disable iff (!aresetn)
        running && tick_end && !ch.start && !ch.clear
        |=> timer_q == $past(timer_q) + 32'h1)
        else $error("counter did not step");
    a_clear_empty: assert property (@(posedge aclk) disable iff (!aresetn)
        ch.clear |=> empty && !running && timer_q == 32'h0)
        else $error("clear incomplete");
    a_abs_match: assert property (@(posedge aclk) disable iff (!aresetn)
        fire && !ch.rel_mode |-> head_ts == timer_q)
        else $error("absolute output off stamp");
    a_pop_order: assert property (@(posedge aclk) disable iff (!aresetn)
        fire |=> rd_q == $past(rd_q) + 1'b1)
        else $error("queue not served in order");
endmodule

/* hw/teo_top.sv */
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module teo_top import teo_pkg::*; #(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sync_start,
    output logic [31:0] output_lines_low_group,
    output logic [HI_W-1:0] output_lines_high_group
);

    if (DEPTH < 2 || DEPTH > 511) begin : g_chk
        $error("teo_top: queue depth out of range");
    end

    // ***************************************************
    // helpers
    // ***************************************************
    // channel c owns the 32-byte window at (c + 1) * 32
    function automatic logic ch_hit(input logic [7:0] a, input int c);
        return a[7:CH_SEL_LSB] == 3'(c + 1);
    endfunction

    function automatic logic ch_known(input logic [4:0] o);
        return o == O_MODE || o == O_ENABLE || o == O_PATTERN
            || o == O_STAMP || o == O_FREE || o == O_TIMER;
    endfunction

    function automatic logic [31:0] merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] strb
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ***************************************************
    // write channel
    // ***************************************************
    logic aw_free_q, w_free_q, bvalid_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic [1:0] bresp_q;

    wire aw_take = s_axi_awvalid && aw_free_q;
    wire w_take = s_axi_wvalid && w_free_q;
    wire b_done = bvalid_q && s_axi_bready;
    wire do_wr = !aw_free_q && !w_free_q && !bvalid_q;
    wire [4:0] w_off = aw_addr_q[4:0];
    wire w_glob = (aw_addr_q[7:CH_SEL_LSB] == 3'h0);
    wire w_wr_ok = (w_glob && aw_addr_q <= A_STATUS
        && aw_addr_q[1:0] == 2'h0)
        || ((ch_hit(aw_addr_q, 0) || ch_hit(aw_addr_q, 1))
        && ch_known(w_off));
    wire wr_start = do_wr && aw_addr_q == A_START;
    wire wr_clear = do_wr && aw_addr_q == A_CLEAR;

    // address and data are held apart until both are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_free_q <= 1'b1;
            w_free_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else begin
            if (aw_take) begin
                aw_free_q <= 1'b0;
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                w_free_q <= 1'b0;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_wr) begin
                bvalid_q <= 1'b1;
                bresp_q <= w_wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (b_done) begin
                bvalid_q <= 1'b0;
                aw_free_q <= 1'b1;
                w_free_q <= 1'b1;
            end
        end
    end

    assign s_axi_awready = aw_free_q;
    assign s_axi_wready = w_free_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // ***************************************************
    // global registers
    // ***************************************************
    logic [31:0] static_lo_q;
    logic [HI_W-1:0] static_hi_q;
    logic [1:0] sync_mask_q;
    // a function result cannot be sliced, so merge into a named word
    wire [31:0] static_hi_m = merge({22'h0, static_hi_q}, w_data_q,
        w_strb_q);

    // lines outside the enable masks come from these
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            static_lo_q <= STATIC_RST;
            static_hi_q <= STATIC_RST[HI_W-1:0];
            sync_mask_q <= SYNC_MASK_RST;
        end else if (do_wr) begin
            if (aw_addr_q == A_STATIC_LO) begin
                static_lo_q <= merge(static_lo_q, w_data_q, w_strb_q);
            end
            if (aw_addr_q == A_STATIC_HI) begin
                static_hi_q <= static_hi_m[HI_W-1:0];
            end
            if (aw_addr_q == A_SYNC_MASK && w_strb_q[0]) begin
                sync_mask_q <= w_data_q[1:0];
            end
        end
    end

    // ***************************************************
    // channels
    // ***************************************************
    teo_chan_if chan_if [NUM_CH] ();

    wire [31:0] static_lane [NUM_CH];
    wire [31:0] lane_d [NUM_CH];
    wire [31:0] ch_rd [NUM_CH];
    wire [NUM_CH-1:0] run_w;
    wire [NUM_CH-1:0] fire_w;
    wire [NUM_CH-1:0] start_w;
    wire [NUM_CH-1:0] clear_w;
    wire [31:0] fpat_w [NUM_CH];
    wire [9:0] free_w [NUM_CH];

    assign static_lane[0] = static_lo_q;
    assign static_lane[1] = {22'h0, static_hi_q};

    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        logic [1:0] mode_q;
        logic [31:0] enable_q, pattern_q, held_q;
        wire hit = do_wr && ch_hit(aw_addr_q, g);
        wire [4:0] r_off = s_axi_araddr[4:0];
        // a fresh pattern is used in the same cycle it fires
        wire [31:0] held_d = fire_w[g] ? fpat_w[g] : held_q;

        // software mode, mask and staged pattern
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                mode_q <= MODE_RST;
                enable_q <= ENABLE_RST;
                pattern_q <= '0;
                held_q <= '0;
            end else begin
                held_q <= held_d;
                if (hit && w_off == O_MODE && w_strb_q[0]) begin
                    mode_q <= w_data_q[MODE_LSB +: 2];
                end
                if (hit && w_off == O_ENABLE) begin
                    enable_q <= merge(enable_q, w_data_q, w_strb_q);
                end
                if (hit && w_off == O_PATTERN) begin
                    pattern_q <= merge(pattern_q, w_data_q, w_strb_q);
                end
            end
        end

        // bit g of the mask picks this channel
        assign start_w[g] = (wr_start && w_data_q[g])
            || (sync_start && sync_mask_q[g]);
        assign clear_w[g] = wr_clear && w_data_q[g];
        assign chan_if[g].start = start_w[g];
        assign chan_if[g].clear = clear_w[g];
        assign chan_if[g].rel_mode = (mode_q == MODE_REL);
        // the stamp write pushes the staged pattern with it
        assign chan_if[g].push = hit && w_off == O_STAMP;
        assign chan_if[g].push_pat = pattern_q;
        assign chan_if[g].push_ts = w_data_q;
        assign run_w[g] = chan_if[g].running;
        assign fire_w[g] = chan_if[g].fire;
        assign fpat_w[g] = chan_if[g].fire_pat;
        assign free_w[g] = chan_if[g].free;
        assign lane_d[g] = (enable_q & held_d)
            | (~enable_q & static_lane[g]);
        assign ch_rd[g] =
            r_off == O_MODE ? {30'h0, mode_q} :
            r_off == O_ENABLE ? enable_q :
            r_off == O_PATTERN ? pattern_q :
            r_off == O_FREE ? {22'h0, free_w[g]} :
            r_off == O_TIMER ? chan_if[g].timer : 32'h0;

        teo_channel #(
            .DEPTH(DEPTH),
            .DIV(TICK_DIV)
        ) u_ch (
            .aclk(aclk),
            .aresetn(aresetn),
            .ch(chan_if[g])
        );
    end

    // ***************************************************
    // output lines
    // ***************************************************
    logic [31:0] out_lo_q;
    logic [HI_W-1:0] out_hi_q;

    // registered so the pins never see decode glitches
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_lo_q <= STATIC_RST;
            out_hi_q <= STATIC_RST[HI_W-1:0];
        end else begin
            out_lo_q <= lane_d[0];
            out_hi_q <= lane_d[1][HI_W-1:0];
        end
    end

    assign output_lines_low_group = out_lo_q;
    assign output_lines_high_group = out_hi_q;

    // ***************************************************
    // read channel
    // ***************************************************
    logic ar_free_q, rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    wire ar_take = s_axi_arvalid && ar_free_q;
    wire [7:0] ra = s_axi_araddr;
    wire r_glob = (ra[7:CH_SEL_LSB] == 3'h0);
    wire r_ok = (r_glob && ra <= A_STATUS && ra[1:0] == 2'h0)
        || ((ch_hit(ra, 0) || ch_hit(ra, 1)) && ch_known(ra[4:0]));
    wire [31:0] glob_rd =
        ra == A_SYNC_MASK ? {30'h0, sync_mask_q} :
        ra == A_STATIC_LO ? static_lo_q :
        ra == A_STATIC_HI ? {22'h0, static_hi_q} :
        ra == A_STATUS ? {30'h0, run_w} : 32'h0;
    wire [31:0] rd_mux = !r_ok ? 32'h0 :
        ch_hit(ra, 0) ? ch_rd[0] :
        ch_hit(ra, 1) ? ch_rd[1] : glob_rd;

    // data is captured at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_free_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (ar_take) begin
            ar_free_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= r_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            ar_free_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_arready = ar_free_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // ***************************************************
    // checks
    // ***************************************************
    sequence s_wr_ready;
        !aw_free_q && !w_free_q && !bvalid_q;
    endsequence

    a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        s_wr_ready |=> bvalid_q ##0 !aw_free_q[*1])
        else $error("write not answered");
    a_read_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_take |=> rvalid_q && !ar_free_q)
        else $error("read not answered");
    a_start_runs: assert property (@(posedge aclk) disable iff (!aresetn)
        start_w[1] && !clear_w[1] |=> run_w[1])
        else $error("channel 2 did not start");
    a_lo_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        fire_w[0] |=> out_lo_q == (($past(fpat_w[0])
        & $past(g_ch[0].enable_q))
        | ($past(static_lo_q) & ~$past(g_ch[0].enable_q))))
        else $error("low lines miss pattern");
    a_hi_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        fire_w[1] && g_ch[1].enable_q[HI_W-1:0] == 10'h3ff
        |=> out_hi_q == $past(fpat_w[1][HI_W-1:0]))
        else $error("high lines miss pattern");
    a_lines_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        !fire_w[0] && $stable(g_ch[0].enable_q) && $stable(static_lo_q)
        ##1 !fire_w[0] && $stable(g_ch[0].enable_q)
        && $stable(static_lo_q) |=> $stable(out_lo_q))
        else $error("low lines changed without cause");
    a_free_drop: assert property (@(posedge aclk) disable iff (!aresetn)
        chan_if[0].push && free_w[0] != 10'h0 && !fire_w[0]
        && !clear_w[0] |=> free_w[0] == $past(free_w[0]) - 10'h1)
        else $error("push did not take a slot");
endmodule

/* verification/teo_line_watch.sv */
`timescale 1ns/10ps
module teo_line_watch (
    input wire logic aclk,
    input wire logic [41:0] lines
);
    // passive far end: no drive back, it only logs level changes
    int cyc = 0;
    logic [41:0] last = '0;
    logic [41:0] seen[$];
    int at[$];
    // sampled mid-cycle so the launching edge has settled
    always @(negedge aclk) begin
        cyc <= cyc + 1;
        if (lines !== last) begin
            seen.push_back(lines);
            at.push_back(cyc);
        end
        last <= lines;
    end
endmodule

/* verification/timed_edge_output_fifo_bench.sv */
`timescale 1ns/10ps
module timed_edge_output_fifo_bench import teo_pkg::*;;
    localparam int DEP = 4;
    logic aclk = 0, aresetn = 0, sync_start = 0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, rd, seed = 32'd48;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, output_lines_low_group;
    logic [9:0] output_lines_high_group;
    logic [31:0] p[5];
    int bad_count = 0, cmp_count = 0, t0;
    teo_top #(.DEPTH(DEP)) dut_u (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .sync_start, .output_lines_low_group, .output_lines_high_group);
    teo_line_watch w (.aclk(aclk),
        .lines({output_lines_high_group, output_lines_low_group}));
    initial begin
        forever #2.5 aclk = ~aclk;
    end
    // ***************************************************
    // bus tasks and checks
    // ***************************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // both channels offered together; each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tb = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            n++;
        end while (!tb && n < 200);
        s_axi_bready <= 1'b0;
        if (!tb) bad_count++;
    endtask
    task automatic rdr(input logic [7:0] a);
        logic ta, tr;
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = s_axi_arvalid & s_axi_arready;
            tr = s_axi_rvalid;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            n++;
        end while (!tr && n < 200);
        s_axi_rready <= 1'b0;
        if (!tr) bad_count++;
    endtask
    // pattern goes first, the stamp write pushes the pair
    task automatic push(input logic [2:0] c, input logic [31:0] d, t);
        wr({c, O_PATTERN}, d);
        wr({c, O_STAMP}, t);
    endtask
    task automatic test_done();
        $display("counts: compares=%0d mismatches=%0d", cmp_count,
            bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // whole run needs a few hundred cycles; this is a generous cap
    initial begin
        #50000;
        bad_count++;
        test_done();
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rdr({3'h1, O_FREE});
        chk(rd, DEP);
        rdr({3'h1, O_MODE});
        chk(rd, MODE_ABS);
        rdr({3'h1, O_TIMER});
        chk(rd, 0);
        chk(output_lines_low_group, 0);
        rdr(8'hfc);
        chk(rsp, RESP_SLVERR);
        wr(8'hfc, 1);
        chk(rsp, RESP_SLVERR);
        $display("test reset and map done");
        p[0] = rnd();
        wr(A_STATIC_LO, p[0]);
        repeat (2) @(negedge aclk);
        chk(output_lines_low_group, p[0]);
        wr({3'h1, O_ENABLE}, 32'hffffffff);
        repeat (2) @(negedge aclk);
        chk(output_lines_low_group, 0);
        // one push past full: the last pair must be dropped
        for (int i = 0; i < 5; i++) begin
            p[i] = rnd();
            push(3'h1, p[i], 20 + 10 * i);
        end
        rdr({3'h1, O_FREE});
        chk(rd, 0);
        w.seen.delete();
        w.at.delete();
        @(posedge aclk);
        sync_start <= 1'b1;
        t0 = w.cyc;
        @(posedge aclk);
        sync_start <= 1'b0;
        repeat (150) @(posedge aclk);
        chk(w.seen.size(), DEP);
        for (int i = 0; i < DEP; i++)
            chk(w.seen[i][31:0], p[i]);
        chk((w.at[0] - t0) inside {[41:45]}, 1);
        chk(w.at[1] - w.at[0], 20);
        rdr({3'h1, O_FREE});
        chk(rd, DEP);
        $display("test absolute done");
        // sync start left channel 2 running: stop it so pushes wait
        wr(A_CLEAR, 2);
        wr({3'h2, O_MODE}, 3);
        wr({3'h2, O_ENABLE}, 32'hffffffff);
        p[0] = rnd();
        p[1] = rnd();
        push(3'h2, p[0], 8);
        push(3'h2, p[1], 12);
        w.seen.delete();
        w.at.delete();
        wr(A_START, 2);
        repeat (80) @(posedge aclk);
        chk(w.seen.size(), 2);
        chk(w.seen[0][41:32], p[0][9:0]);
        chk(w.seen[1][41:32], p[1][9:0]);
        chk(w.at[1] - w.at[0], 24);
        $display("test relative done");
        push(3'h1, rnd(), 32'h0000ffff);
        wr(A_CLEAR, 1);
        rdr({3'h1, O_FREE});
        chk(rd, DEP);
        rdr({3'h1, O_TIMER});
        chk(rd, 0);
        $display("test clear done");
        test_done();
    end
endmodule
